// [logic/gop_pkg.sv]
// Constants for the global output pin control block.
// Assumes a 125 MHz pclk and an APB register port with 32-bit data.
package gop_pkg;
    localparam int unsigned CLK_MHZ = 125;
    // Watchdog pulse timing, in nanoseconds and in pclk cycles.
    localparam int unsigned PULSE_MIN_NS = 30500;
    localparam int unsigned PULSE_MAX_NS = 61000;
    localparam int unsigned PULSE_MIN_CYC = (PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned PULSE_MAX_CYC = (PULSE_MAX_NS * CLK_MHZ) / 1000;
    localparam int unsigned PULSE_CNT_W = 14;
    // Register indices; the byte address is four times the index.
    localparam logic [5:0] CTRL_IDX = 6'h0E;
    localparam logic [5:0] STAT_IDX = 6'h0F;
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // Control field positions.
    localparam int unsigned CLK_SEL_LSB = 6;
    localparam int unsigned CYC_SEL_LSB = 4;
    localparam int unsigned WDT_FORCE_BIT = 3;
    localparam int unsigned BUF_SEL_LSB = 0;
    // Status field positions.
    localparam int unsigned ST_LIVE_LSB = 0;
    localparam int unsigned ST_BOOT_LSB = 2;
    localparam int unsigned ST_DONE_BIT = 4;
    localparam int unsigned ST_WDT_BIT = 5;
    // Common encoding of the three two-bit pin selectors.
    localparam logic [1:0] SEL_FUNC_A = 2'h0;
    localparam logic [1:0] SEL_FUNC_B = 2'h1;
    localparam logic [1:0] SEL_LOW = 2'h2;
    localparam logic [1:0] SEL_HIGH = 2'h3;
endpackage : gop_pkg

// [logic/wdt_pulse_if.sv]
// Carrier between the pin control top and its watchdog pulse timer.
// Assumes both ends run on the same pclk.
`timescale 1ns/1ps
interface wdt_pulse_if;
    logic start_prog;
    logic start_wdt;
    logic pin_low;
    modport ctrl (output start_prog, output start_wdt, input pin_low);
    modport timer (input start_prog, input start_wdt, output pin_low);
endinterface : wdt_pulse_if

// [logic/wdt_pulse_timer.sv]
// Times the active-low pulse on the watchdog output pin.
// Assumes one-cycle start strobes and a pclk at the package rate.
`timescale 1ns/1ps
module wdt_pulse_timer #(
    parameter int unsigned PULSE_CYCLES = gop_pkg::PULSE_MIN_CYC
) (
    input wire logic pclk, // Clock.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic ce, // Clock enable; freezes state when low.
    wdt_pulse_if.timer pio // Start strobes and pulse level.
);
    import gop_pkg::*;

    typedef enum logic {IDLE, LOW} pulse_e;
    localparam logic [PULSE_CNT_W-1:0] LAST = PULSE_CNT_W'(PULSE_CYCLES - 1);

    pulse_e state_ff, nxt_state;
    logic [PULSE_CNT_W-1:0] cnt_ff, nxt_cnt;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        unique case (state_ff)
            IDLE: begin
                // RQ5 pulse length window
                if (pio.start_prog || pio.start_wdt) begin
                    nxt_state = LOW;
                    nxt_cnt = '0;
                end
            end
            LOW: begin
                // RQ4 bounded low time
                if (cnt_ff == LAST) begin
                    nxt_state = IDLE;
                end else begin
                    nxt_cnt = cnt_ff + 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= IDLE;
            cnt_ff <= '0;
        end else if (ce) begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    assign pio.pin_low = (state_ff == LOW);
endmodule : wdt_pulse_timer

// [logic/global_output_pin_control.sv]
// Global output pin control: selects the sources of four dedicated output pins
// and captures the boot select pins.
// Assumes all inputs are synchronous to pclk and an APB master on the register port.
//
// What this block does
// RQ1: Bits 7:6 pick clock pin: peripheral clock, halved, low, high.
// RQ2: Bits 5:4 pick cycle pin: opcode fetch, interrupt ack, low, high.
// RQ3: Bit 3 clear follows watchdog; writing it set forces pin low.
// RQ4: Forced low lasts one to two periods of the 32 kHz oscillator.
// RQ5: Program pulse lasts between 30.5 and 61 microseconds.
// RQ6: Watchdog timeout gives 30.5 us low pulse and resets processor.
// RQ7: Bits 1:0 at 00 assert buffer enable low on external I/O cycles.
// RQ8: 01 asserts buffer enable on data memory; 10 low; 11 high.
// RQ9: Boot pins select boot mode, then read as plain inputs.
// RQ10: Bit 2 is ignored; new value reaches pins next cycle.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
module global_output_pin_control #(
    parameter int unsigned PULSE_CYCLES = gop_pkg::PULSE_MIN_CYC
) (
    input wire logic pclk, // Processor clock, 125 MHz.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic ce, // Clock enable; freezes all state when low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction, high for write.
    input wire logic [gop_pkg::ADDR_W-1:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error on unmapped address.
    input wire logic periph_clk, // Peripheral clock level.
    input wire logic first_opcode_fetch, // High during first opcode byte fetch.
    input wire logic int_ack, // High during interrupt acknowledge.
    input wire logic ext_io_cycle, // High during external I/O cycles.
    input wire logic data_mem_access, // High during data memory accesses.
    input wire logic wdt_timeout, // One-cycle watchdog timeout event.
    input wire logic boot_select_pin_0, // Boot select pin 0.
    input wire logic boot_select_pin_1, // Boot select pin 1.
    input wire logic boot_done, // High once boot has completed.
    output logic clk_pin, // Clock output pin.
    output logic cycle_pin_n, // Cycle indicator pin, active low.
    output logic watchdog_timeout_pin_n, // Watchdog output pin, active low.
    output logic buffer_enable_pin_n, // Buffer enable pin, active low.
    output logic cpu_reset_req, // One-cycle processor reset request.
    output logic [1:0] boot_mode // Boot mode caught after reset.
);
    import gop_pkg::*;

    wdt_pulse_if pio ();

    wdt_pulse_timer #(.PULSE_CYCLES(PULSE_CYCLES)) u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .pio(pio)
    );

    logic [7:0] ctrl_ff, nxt_ctrl;
    logic pready_ff, nxt_pready;
    logic pslverr_ff, nxt_pslverr;
    logic [31:0] prdata_ff, nxt_prdata;
    logic prog_start_ff, nxt_prog_start;
    logic clk_pin_ff, nxt_clk_pin;
    logic clk_half_ff, nxt_clk_half;
    logic periph_prev_ff;
    logic cycle_n_ff, nxt_cycle_n;
    logic wdt_n_ff;
    logic buf_n_ff, nxt_buf_n;
    logic rst_req_ff;
    logic caught_ff;
    logic [1:0] boot_ff, nxt_boot;
    logic [1:0] live_ff, nxt_live;

    logic access, hit_ctrl, hit_stat, done;
    logic [1:0] clk_sel, cyc_sel, buf_sel;

    assign access = psel && penable;
    assign hit_ctrl = (paddr == {CTRL_IDX, 2'b00});
    assign hit_stat = (paddr == {STAT_IDX, 2'b00});
    assign done = access && pready_ff;
    assign clk_sel = ctrl_ff[CLK_SEL_LSB +: 2];
    assign cyc_sel = ctrl_ff[CYC_SEL_LSB +: 2];
    assign buf_sel = ctrl_ff[BUF_SEL_LSB +: 2];

    // One wait state lets every APB output come from a flop.
    always_comb begin
        nxt_pready = access && !pready_ff;
        nxt_pslverr = 1'b0;
        nxt_prdata = 32'h0000_0000;
        nxt_ctrl = ctrl_ff;
        nxt_prog_start = 1'b0;
        if (access && !pready_ff) begin
            nxt_pslverr = !(hit_ctrl || hit_stat);
            if (!pwrite && hit_stat) begin
                nxt_prdata[ST_LIVE_LSB +: 2] = live_ff;
                nxt_prdata[ST_BOOT_LSB +: 2] = boot_ff;
                nxt_prdata[ST_DONE_BIT] = boot_done;
                nxt_prdata[ST_WDT_BIT] = pio.pin_low;
            end
        end
        if (done && pwrite && hit_ctrl) begin
            nxt_ctrl = pwdata[7:0];
            // RQ3 program forced pulse
            nxt_prog_start = pwdata[WDT_FORCE_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            ctrl_ff <= CTRL_RESET;
            prog_start_ff <= 1'b0;
        end else if (ce) begin
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff <= nxt_prdata;
            ctrl_ff <= nxt_ctrl;
            prog_start_ff <= nxt_prog_start;
        end
    end

    assign pio.start_prog = prog_start_ff;
    // RQ6 timeout pulse start
    assign pio.start_wdt = wdt_timeout;

    // Pin selection; bit 2 of the control value is never read.
    always_comb begin
        nxt_clk_half = clk_half_ff;
        if (periph_clk && !periph_prev_ff) begin
            nxt_clk_half = !clk_half_ff;
        end
        // RQ1 clock pin source
        unique case (clk_sel)
            SEL_FUNC_A: nxt_clk_pin = periph_clk;
            SEL_FUNC_B: nxt_clk_pin = clk_half_ff;
            SEL_LOW: nxt_clk_pin = 1'b0;
            SEL_HIGH: nxt_clk_pin = 1'b1;
        endcase
        // RQ2 cycle indicator source
        unique case (cyc_sel)
            SEL_FUNC_A: nxt_cycle_n = !first_opcode_fetch;
            SEL_FUNC_B: nxt_cycle_n = !int_ack;
            SEL_LOW: nxt_cycle_n = 1'b0;
            SEL_HIGH: nxt_cycle_n = 1'b1;
        endcase
        // RQ7 RQ8 buffer enable source
        unique case (buf_sel)
            SEL_FUNC_A: nxt_buf_n = !ext_io_cycle;
            SEL_FUNC_B: nxt_buf_n = !data_mem_access;
            SEL_LOW: nxt_buf_n = 1'b0;
            SEL_HIGH: nxt_buf_n = 1'b1;
        endcase
    end

    // RQ10 pins follow next cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_pin_ff <= 1'b0;
            clk_half_ff <= 1'b0;
            periph_prev_ff <= 1'b0;
            cycle_n_ff <= 1'b1;
            wdt_n_ff <= 1'b1;
            buf_n_ff <= 1'b1;
            rst_req_ff <= 1'b0;
        end else if (ce) begin
            clk_pin_ff <= nxt_clk_pin;
            clk_half_ff <= nxt_clk_half;
            periph_prev_ff <= periph_clk;
            cycle_n_ff <= nxt_cycle_n;
            wdt_n_ff <= !pio.pin_low;
            buf_n_ff <= nxt_buf_n;
            // RQ6 processor reset request
            rst_req_ff <= wdt_timeout;
        end
    end

    // Boot pins are caught on the first enabled edge after reset release.
    always_comb begin
        nxt_boot = boot_ff;
        nxt_live = live_ff;
        // RQ9 boot mode capture
        if (!caught_ff) begin
            nxt_boot = {boot_select_pin_1, boot_select_pin_0};
        end
        // RQ9 plain inputs after boot
        if (boot_done) begin
            nxt_live = {boot_select_pin_1, boot_select_pin_0};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            caught_ff <= 1'b0;
            boot_ff <= 2'h0;
            live_ff <= 2'h0;
        end else if (ce) begin
            caught_ff <= 1'b1;
            boot_ff <= nxt_boot;
            live_ff <= nxt_live;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign clk_pin = clk_pin_ff;
    assign cycle_pin_n = cycle_n_ff;
    assign watchdog_timeout_pin_n = wdt_n_ff;
    assign buffer_enable_pin_n = buf_n_ff;
    assign cpu_reset_req = rst_req_ff;
    assign boot_mode = boot_ff;
endmodule : global_output_pin_control

// [dv/gop_asserts.sv]
// Checker for the global output pin control block.
// Assumes ce is held high and the block's ports are bound by name.
`timescale 1ns/1ps
module gop_asserts #(
    parameter int unsigned PULSE_CYCLES = 8
) (
    input wire logic pclk, // Clock.
    input wire logic presetn, // Reset.
    input wire logic psel, // Select.
    input wire logic penable, // Enable.
    input wire logic pwrite, // Write.
    input wire logic [gop_pkg::ADDR_W-1:0] paddr, // Address.
    input wire logic [31:0] pwdata, // Data.
    input wire logic pready, // Ready.
    input wire logic periph_clk, // Clock in.
    input wire logic first_opcode_fetch, // Fetch.
    input wire logic int_ack, // Ack.
    input wire logic ext_io_cycle, // I/O.
    input wire logic data_mem_access, // Memory.
    input wire logic wdt_timeout, // Timeout.
    input wire logic boot_select_pin_0, // Boot 0.
    input wire logic boot_select_pin_1, // Boot 1.
    input wire logic clk_pin, // Clock pin.
    input wire logic cycle_pin_n, // Cycle pin.
    input wire logic watchdog_timeout_pin_n, // Dog pin.
    input wire logic buffer_enable_pin_n, // Buffer pin.
    input wire logic cpu_reset_req, // Reset out.
    input wire logic [1:0] boot_mode // Mode.
);
    import gop_pkg::*;
    logic [7:0] ctrl_ff, nxt_ctrl;
    logic [1:0] up_ff, nxt_up;
    logic [15:0] low_ff, nxt_low;
    logic wr_ctrl, exp_clk, exp_cyc_n, exp_buf_n;
    // The write-only register is shadowed here because it cannot be read back.
    assign wr_ctrl = psel && penable && pready && pwrite && (paddr == {CTRL_IDX, 2'h0});
    always_comb begin
        nxt_ctrl = wr_ctrl ? pwdata[7:0] : ctrl_ff;
        nxt_up = (up_ff == 2'h3) ? up_ff : up_ff + 2'h1;
        nxt_low = watchdog_timeout_pin_n ? 16'h0000 : low_ff + 16'h0001;
        exp_clk = ctrl_ff[7] ? ctrl_ff[6] : periph_clk;
        exp_cyc_n = ctrl_ff[5] ? ctrl_ff[4] : (ctrl_ff[4] ? !int_ack : !first_opcode_fetch);
        exp_buf_n = ctrl_ff[1] ? ctrl_ff[0] : (ctrl_ff[0] ? !data_mem_access : !ext_io_cycle);
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= CTRL_RESET;
            up_ff <= 2'h0;
            low_ff <= 16'h0000;
        end else begin
            ctrl_ff <= nxt_ctrl;
            up_ff <= nxt_up;
            low_ff <= nxt_low;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    clk_pin_a: assert property (up_ff != 2'h0 && $past(ctrl_ff[7:6]) != 2'h1
        |-> clk_pin == $past(exp_clk)) else $error("clock pin differs from source");
    cyc_pin_a: assert property (up_ff != 2'h0 |-> cycle_pin_n == $past(exp_cyc_n))
        else $error("cycle pin differs from source");
    buf_pin_a: assert property (up_ff != 2'h0 |-> buffer_enable_pin_n == $past(exp_buf_n))
        else $error("buffer pin differs from source");
    force_low_a: assert property (wr_ctrl && pwdata[3] && watchdog_timeout_pin_n
        |-> ##[1:5] !watchdog_timeout_pin_n) else $error("forced pulse missing");
    dog_start_a: assert property (wdt_timeout && watchdog_timeout_pin_n
        |-> ##[1:4] !watchdog_timeout_pin_n) else $error("timeout pulse missing");
    cpu_reset_a: assert property (up_ff != 2'h0 |-> cpu_reset_req == $past(wdt_timeout))
        else $error("reset request mismatch");
    pulse_len_a: assert property ($rose(watchdog_timeout_pin_n) |-> low_ff == PULSE_CYCLES)
        else $error("watchdog pulse length wrong");
    boot_cap_a: assert property (up_ff == 2'h1
        |-> boot_mode == $past({boot_select_pin_1, boot_select_pin_0}))
        else $error("boot mode not captured");
    boot_hold_a: assert property (up_ff[1] |-> $stable(boot_mode))
        else $error("boot mode changed");
    apb_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("ready timing wrong");
    cover property (wr_ctrl);
    cover property ($rose(watchdog_timeout_pin_n));
    cover property (cpu_reset_req);
endmodule : gop_asserts
bind global_output_pin_control gop_asserts #(.PULSE_CYCLES(PULSE_CYCLES)) chk (.*);

// [dv/global_output_pin_control_tb_top.sv]
// Testbench for the global output pin control block.
// Assumes the bound checker and a shortened watchdog pulse.
`timescale 1ns/1ps
module global_output_pin_control_tb_top;
    import gop_pkg::*;
    localparam int unsigned PULSE = 8;
    localparam logic [7:0] CTRL_A = {CTRL_IDX, 2'h0};
    localparam logic [7:0] STAT_A = {STAT_IDX, 2'h0};
    logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, last, clk_pin, cycle_pin_n, watchdog_timeout_pin_n;
    logic periph_clk = 1'b0, first_opcode_fetch = 1'b0, int_ack = 1'b0, ext_io_cycle = 1'b0;
    logic data_mem_access = 1'b0, wdt_timeout = 1'b0, boot_done = 1'b0;
    logic boot_select_pin_0 = 1'b0, boot_select_pin_1 = 1'b1;
    logic buffer_enable_pin_n, cpu_reset_req;
    logic [1:0] boot_mode;
    int err_total = 0, check_count = 0, len, toggles;
    global_output_pin_control #(.PULSE_CYCLES(PULSE)) uut (.*);
    always #4 pclk = ~pclk;
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        check(n < 20, 1'b1, "ready never came");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Counts low samples of the watchdog pin over a window longer than any pulse.
    task automatic pulse_len();
        len = 0;
        repeat (40) begin
            @(negedge pclk);
            if (watchdog_timeout_pin_n === 1'b0) len++;
        end
    endtask : pulse_len
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    initial begin
        #100000;
        err_total++;
        $display("[ERR] %0t watchdog expired", $time);
        tally_and_finish();
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, STAT_A, 32'h0);
        check(rd, 32'h8, "status before boot");
        apb(1'b0, CTRL_A, 32'h0);
        check(rd, 32'h0, "control read");
        check(er, 1'b0, "control read error");
        apb(1'b1, 8'h40, 32'hFF);
        check(er, 1'b1, "unmapped write");
        $display("register access test done");
        for (int s = 0; s < 4; s++) begin
            for (int v = 0; v < 2; v++) begin
                apb(1'b1, CTRL_A, {24'h0, s[1:0], s[1:0], 2'b01, s[1:0]});
                periph_clk <= v[0];
                first_opcode_fetch <= v[0];
                ext_io_cycle <= v[0];
                int_ack <= ~v[0];
                data_mem_access <= ~v[0];
                repeat (3) @(negedge pclk);
                if (s != 1) check(clk_pin, s[1] ? s[0] : v[0], "clock pin");
                // A logical not keeps the expectation one bit wide in the 32-bit compare.
                check(cycle_pin_n, s[1] ? s[0] : !(s[0] ^ v[0]), "cycle pin");
                check(buffer_enable_pin_n, s[1] ? s[0] : !(s[0] ^ v[0]), "buffer pin");
            end
        end
        $display("pin select test done");
        apb(1'b1, CTRL_A, 32'h40);
        repeat (4) @(negedge pclk);
        toggles = 0;
        last = clk_pin;
        for (int i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (i < 16 && i % 2 == 0) periph_clk <= ~periph_clk;
            @(negedge pclk);
            if (clk_pin !== last) toggles++;
            last = clk_pin;
        end
        check(toggles, 4, "halved clock edges");
        $display("halved clock test done");
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, CTRL_A, (k < 2) ? 32'h08 : 32'h00);
            pulse_len();
            check(len, (k < 2) ? PULSE : 0, "forced pulse length");
        end
        $display("forced pulse test done");
        // A second timeout inside the pulse must neither stretch nor repeat it.
        fork
            pulse_len();
            for (int k = 0; k < 2; k++) begin
                @(posedge pclk);
                wdt_timeout <= 1'b1;
                @(posedge pclk);
                wdt_timeout <= 1'b0;
                @(negedge pclk);
                check(cpu_reset_req, 1'b1, "reset request");
                repeat (3) @(posedge pclk);
            end
        join
        check(len, PULSE, "timeout pulse length");
        $display("timeout test done");
        @(posedge pclk);
        boot_done <= 1'b1;
        boot_select_pin_0 <= 1'b1;
        boot_select_pin_1 <= 1'b0;
        apb(1'b0, STAT_A, 32'h0);
        check(rd, 32'h19, "status after boot");
        check(boot_mode, 2'b10, "boot mode kept");
        $display("boot pin test done");
        tally_and_finish();
    end
endmodule : global_output_pin_control_tb_top
